// File: rtcaw_div.sv
// Crystal divider: synchronises the 32.768 kHz oscillator pin and
// derives the square-wave taps and the free-running 32 Hz tick.
// Assumes MCLK is far faster than the oscillator.
`timescale 1ns/100ps
`default_nettype none
module rtcaw_div
	import rtcaw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Oscillator pin
	input wire logic osc_pin,
	// Divided outputs
	output logic tick32,
	output logic [3:0] wave
);
	logic osc_s1_r;
	logic osc_s2_r;
	logic osc_d_r;
	logic [RTCAW_DIV_W-1:0] div_r;
	logic osc_rise;

	// ==========================================
	// Two-stage synchroniser, then edge detect
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_d_r <= 1'b0;
		end else begin
			osc_s1_r <= osc_pin;
			osc_s2_r <= osc_s1_r;
			osc_d_r <= osc_s2_r;
		end
	end

	assign osc_rise = osc_s2_r & ~osc_d_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_r <= '0;
		end else if (osc_rise) begin
			div_r <= div_r + 1'b1;
		end
	end

	// Tick is free running and not aligned to any reload
	assign tick32 = osc_rise & (div_r[9:0] == RTCAW_TICK32_LAST);
	assign wave = {osc_s2_r, div_r[RTCAW_TAP_4096HZ], div_r[RTCAW_TAP_512HZ], div_r[RTCAW_TAP_1HZ]};
endmodule
`default_nettype wire

// File: rtcaw_host.sv
// Host microcontroller model: byte writes and reads on the register port.
// Assumes clock and reset come from the bench.
`timescale 1ns/100ps
`default_nettype none
module rtcaw_host
	import rtcaw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	output logic [20:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	logic [2:0] up_r = 3'h0;
	initial begin
		addr = 21'h000000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Pin and bus left alone until power-up has settled
	always @(posedge clk)
		up_r <= !reset_n ? 3'h0 : (up_r == 3'h7 ? up_r : up_r + 3'h1);
	task automatic wait_up();
		while (up_r != 3'h7)
			@(posedge clk);
	endtask
	task automatic wr8(input logic [20:0] a, input logic [7:0] d);
		wait_up();
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd8(input logic [20:0] a, output logic [7:0] d);
		wait_up();
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// Stage alarm fields under the update lock; the caller releases it
	task automatic stage(input logic [6:0] s, input logic [7:0] m, input logic [7:0] h, input logic [7:0] d);
		wr8(RTCAW_OFF_EVENT_FLAGS, 8'h02);
		wr8(RTCAW_OFF_MATCH_SECONDS, {1'b0, s});
		wr8(RTCAW_OFF_MATCH_MINUTES, m);
		wr8(RTCAW_OFF_MATCH_HOURS, h);
		wr8(RTCAW_OFF_MATCH_DATE, d);
	endtask
endmodule
`default_nettype wire

// File: rtcaw_pkg.sv
// Constants shared by the alarm, watchdog and interrupt-pin logic.
// Assumes an 8-bit register port with 21-bit byte addresses.
package rtcaw_pkg;

	// ==========================================
	// Register offsets
	localparam logic [20:0] RTCAW_OFF_EVENT_FLAGS = 21'h1FFFF0;
	localparam logic [20:0] RTCAW_OFF_MATCH_SECONDS = 21'h1FFFF2;
	localparam logic [20:0] RTCAW_OFF_MATCH_MINUTES = 21'h1FFFF3;
	localparam logic [20:0] RTCAW_OFF_MATCH_HOURS = 21'h1FFFF4;
	localparam logic [20:0] RTCAW_OFF_MATCH_DATE = 21'h1FFFF5;
	localparam logic [20:0] RTCAW_OFF_IRQ_CONFIG = 21'h1FFFF6;
	localparam logic [20:0] RTCAW_OFF_TIMEOUT_CONTROL = 21'h1FFFF7;

	// ==========================================
	// event_flags bit positions
	localparam int RTCAW_FL_TIMEOUT = 7;
	localparam int RTCAW_FL_MATCH = 6;
	localparam int RTCAW_FL_SUPPLY_LOSS = 5;
	localparam int RTCAW_FL_BACKUP_FAIL = 4;
	localparam int RTCAW_FL_CAL = 2;
	localparam int RTCAW_FL_UPDATE_LOCK = 1;

	// ==========================================
	// irq_config bit positions
	localparam int RTCAW_IC_TIMEOUT_EN = 7;
	localparam int RTCAW_IC_MATCH_EN = 6;
	localparam int RTCAW_IC_SUPPLY_EN = 5;
	localparam int RTCAW_IC_SQW_EN = 4;
	localparam int RTCAW_IC_HIGH = 3;
	localparam int RTCAW_IC_PULSE = 2;
	localparam int RTCAW_IC_FREQ_HI = 1;
	localparam int RTCAW_IC_FREQ_LO = 0;

	// ==========================================
	// timeout_control bit positions
	localparam int RTCAW_TC_STROBE = 7;
	localparam int RTCAW_TC_WRITE_LOCK = 6;
	localparam int RTCAW_TC_VALUE_MSB = 5;

	// Match-select bit of every alarm field
	localparam int RTCAW_MATCH_SEL = 7;

	// ==========================================
	// Values after reset
	localparam logic [7:0] RTCAW_RST_IRQ_CONFIG = 8'h08;
	localparam logic [5:0] RTCAW_RST_TIMEOUT = 6'h00;
	localparam logic [7:0] RTCAW_RST_MATCH = 8'h80;
	localparam logic [7:0] RTCAW_RST_MATCH_SECONDS = 8'h00;

	// ==========================================
	// Divider taps of the crystal counter
	localparam int RTCAW_DIV_W = 15;
	localparam int RTCAW_TAP_1HZ = 14;
	localparam int RTCAW_TAP_512HZ = 5;
	localparam int RTCAW_TAP_4096HZ = 2;
	localparam logic [9:0] RTCAW_TICK32_LAST = 10'h3FF;

	// ==========================================
	// Timing
	localparam int RTCAW_MCLK_HZ = 25000000;
	localparam int RTCAW_PULSE_MS = 200;
	localparam int RTCAW_PULSE_CYCLES = (RTCAW_MCLK_HZ / 1000) * RTCAW_PULSE_MS;
	localparam logic [1:0] RTCAW_STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		RTCAW_PIN_IDLE = 2'b00,
		RTCAW_PIN_LEVEL = 2'b01,
		RTCAW_PIN_PULSE = 2'b11
	} rtcaw_pin_e;

endpackage

// File: rtcaw_top.sv
// Alarm comparator, watchdog, event flags and interrupt/square-wave pin.
// Assumes the current time comes in BCD from timekeeping on MCLK and
// that the oscillator, supply and backup-fail pins are asynchronous.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module rtcaw_top
	import rtcaw_pkg::*;
#(
	parameter int PULSE_CYCLES = RTCAW_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [20:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Current time, BCD
	input wire logic [7:0] TIME_SECONDS,
	input wire logic [7:0] TIME_MINUTES,
	input wire logic [7:0] TIME_HOURS,
	input wire logic [7:0] TIME_DATE,
	// Oscillator and supply monitors
	input wire logic OSC_32K,
	input wire logic ON_BACKUP,
	input wire logic SUPPLY_LOSS,
	input wire logic BACKUP_FAILED,
	// Interrupt pin
	output logic INT_O,
	output logic INT_OE
);
	logic tick32;
	logic [3:0] wave;
	logic bk_s1_r, bk_s2_r;
	logic pf_s1_r, pf_s2_r, pf_d_r;
	logic bf_s1_r, bf_s2_r;
	logic [1:0] settle_r;
	logic strap_done_r;
	logic host_ok;
	logic wr_ok, rd_ok;
	logic rd_flags, rd_cfg;
	logic [7:0] stage_r [4];
	logic [7:0] match_r [4];
	logic [7:0] now [4];
	logic [3:0] field_ok;
	logic match_now, match_d_r;
	logic lock_r, cal_r;
	logic [7:0] irq_cfg_r;
	logic [5:0] timeout_r;
	logic [5:0] count_r;
	logic strobe;
	logic wd_expire;
	logic fl_timeout_r, fl_match_r, fl_supply_r, fl_backup_r;
	logic set_timeout, set_match, set_supply, set_backup;
	logic pend_nxt, pend_r;
	rtcaw_pin_e pin_r;
	logic [22:0] pulse_cnt_r;
	logic irq_active;
	logic sq_level;

	rtcaw_div u_div (
		.clk(MCLK),
		.reset_n(RESET_N),
		.osc_pin(OSC_32K),
		.tick32(tick32),
		.wave(wave)
	);

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			bk_s1_r <= 1'b0;
			bk_s2_r <= 1'b0;
			pf_s1_r <= 1'b0;
			pf_s2_r <= 1'b0;
			pf_d_r <= 1'b0;
			bf_s1_r <= 1'b0;
			bf_s2_r <= 1'b0;
		end else begin
			bk_s1_r <= ON_BACKUP;
			bk_s2_r <= bk_s1_r;
			pf_s1_r <= SUPPLY_LOSS;
			pf_s2_r <= pf_s1_r;
			pf_d_r <= pf_s2_r;
			bf_s1_r <= BACKUP_FAILED;
			bf_s2_r <= bf_s1_r;
		end
	end

	// Backup-fail level is caught once, after the synchroniser settles
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			settle_r <= '0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			settle_r <= settle_r + 1'b1;
			strap_done_r <= (settle_r == RTCAW_STRAP_SETTLE);
		end
	end

	assign set_backup = !strap_done_r && (settle_r == RTCAW_STRAP_SETTLE) && bf_s2_r;
	assign set_supply = pf_s2_r & ~pf_d_r;

	// ==========================================
	// Register port decode
	assign host_ok = ~bk_s2_r;
	assign wr_ok = WR & host_ok;
	assign rd_ok = RD & host_ok;
	assign rd_flags = rd_ok && (ADDR == RTCAW_OFF_EVENT_FLAGS);
	assign rd_cfg = rd_ok && (ADDR == RTCAW_OFF_IRQ_CONFIG);

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			RDATA <= '0;
		end else if (rd_ok) begin
			case (ADDR)
				RTCAW_OFF_EVENT_FLAGS: RDATA <= {fl_timeout_r, fl_match_r, fl_supply_r, fl_backup_r,
					1'b0, cal_r, lock_r, 1'b0};
				RTCAW_OFF_MATCH_SECONDS: RDATA <= stage_r[0];
				RTCAW_OFF_MATCH_MINUTES: RDATA <= stage_r[1];
				RTCAW_OFF_MATCH_HOURS: RDATA <= stage_r[2];
				RTCAW_OFF_MATCH_DATE: RDATA <= stage_r[3];
				RTCAW_OFF_IRQ_CONFIG: RDATA <= irq_cfg_r;
				RTCAW_OFF_TIMEOUT_CONTROL: RDATA <= {2'b00, timeout_r};
				default: RDATA <= '0;
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// ==========================================
	// Update lock and calibration test bit
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			lock_r <= 1'b0;
			cal_r <= 1'b0;
		end else if (wr_ok && ADDR == RTCAW_OFF_EVENT_FLAGS) begin
			lock_r <= WDATA[RTCAW_FL_UPDATE_LOCK];
			cal_r <= WDATA[RTCAW_FL_CAL];
		end
	end

	// ==========================================
	// Alarm staging and working copies
	generate
		for (genvar i = 0; i < 4; i++) begin : g_field
			always_ff @(posedge MCLK) begin
				if (!RESET_N) begin
					stage_r[i] <= (i == 0) ? RTCAW_RST_MATCH_SECONDS : RTCAW_RST_MATCH;
				end else if (wr_ok && ADDR == RTCAW_OFF_MATCH_SECONDS + 21'(i)) begin
					stage_r[i] <= WDATA;
				end
			end

			always_ff @(posedge MCLK) begin
				if (!RESET_N) begin
					match_r[i] <= (i == 0) ? RTCAW_RST_MATCH_SECONDS : RTCAW_RST_MATCH;
				end else if (wr_ok && ADDR == RTCAW_OFF_EVENT_FLAGS && lock_r
						&& !WDATA[RTCAW_FL_UPDATE_LOCK]) begin
					match_r[i] <= stage_r[i];
				end
			end

			assign field_ok[i] = match_r[i][RTCAW_MATCH_SEL]
				| (match_r[i][RTCAW_MATCH_SEL-1:0] == now[i][RTCAW_MATCH_SEL-1:0]);
		end
	endgenerate

	assign now[0] = TIME_SECONDS;
	assign now[1] = TIME_MINUTES;
	assign now[2] = TIME_HOURS;
	assign now[3] = TIME_DATE;

	// Seconds select left at 1 makes the match last a whole minute; only its start flags
	assign match_now = (&field_ok) & ~(match_r[0][RTCAW_MATCH_SEL] & match_r[1][RTCAW_MATCH_SEL]
		& match_r[2][RTCAW_MATCH_SEL] & match_r[3][RTCAW_MATCH_SEL]);

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			match_d_r <= 1'b0;
		end else begin
			match_d_r <= match_now;
		end
	end

	assign set_match = match_now & ~match_d_r;

	// ==========================================
	// Interrupt configuration
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			irq_cfg_r <= RTCAW_RST_IRQ_CONFIG;
		end else if (wr_ok && ADDR == RTCAW_OFF_IRQ_CONFIG) begin
			irq_cfg_r <= WDATA;
		end
	end

	// ==========================================
	// Watchdog
	assign strobe = wr_ok && (ADDR == RTCAW_OFF_TIMEOUT_CONTROL) && WDATA[RTCAW_TC_STROBE];

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			timeout_r <= RTCAW_RST_TIMEOUT;
		end else if (wr_ok && ADDR == RTCAW_OFF_TIMEOUT_CONTROL && !WDATA[RTCAW_TC_WRITE_LOCK]) begin
			timeout_r <= WDATA[RTCAW_TC_VALUE_MSB:0];
		end
	end

	assign wd_expire = tick32 && !strobe && (timeout_r != '0) && (count_r == 6'h01);

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			count_r <= RTCAW_RST_TIMEOUT;
		end else if (strobe) begin
			count_r <= (wr_ok && !WDATA[RTCAW_TC_WRITE_LOCK]) ? WDATA[RTCAW_TC_VALUE_MSB:0] : timeout_r;
		end else if (timeout_r == '0) begin
			count_r <= timeout_r;
		end else if (tick32) begin
			count_r <= (count_r <= 6'h01) ? timeout_r : count_r - 1'b1;
		end
	end

	assign set_timeout = wd_expire;

	// ==========================================
	// Event flags: set beats read clear
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			fl_timeout_r <= 1'b0;
			fl_match_r <= 1'b0;
			fl_supply_r <= 1'b0;
			fl_backup_r <= 1'b0;
		end else begin
			fl_timeout_r <= set_timeout | (fl_timeout_r & ~rd_flags);
			fl_match_r <= set_match | (fl_match_r & ~rd_flags);
			fl_supply_r <= set_supply | (fl_supply_r & ~rd_flags);
			fl_backup_r <= set_backup | (fl_backup_r & ~rd_flags);
		end
	end

	// ==========================================
	// Interrupt pin state
	assign pend_nxt = (set_timeout & irq_cfg_r[RTCAW_IC_TIMEOUT_EN])
		| (set_match & irq_cfg_r[RTCAW_IC_MATCH_EN])
		| (set_supply & irq_cfg_r[RTCAW_IC_SUPPLY_EN]);

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt & host_ok;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			pin_r <= RTCAW_PIN_IDLE;
			pulse_cnt_r <= '0;
		end else begin
			case (pin_r)
				RTCAW_PIN_IDLE: begin
					if (pend_r) begin
						pin_r <= irq_cfg_r[RTCAW_IC_PULSE] ? RTCAW_PIN_PULSE : RTCAW_PIN_LEVEL;
						pulse_cnt_r <= 23'(PULSE_CYCLES - 1);
					end
				end
				RTCAW_PIN_LEVEL: begin
					if ((rd_flags || rd_cfg) && !pend_r) begin
						pin_r <= RTCAW_PIN_IDLE;
					end
				end
				RTCAW_PIN_PULSE: begin
					if (rd_flags && !pend_r) begin
						pin_r <= RTCAW_PIN_IDLE;
					end else if (pulse_cnt_r == '0) begin
						pin_r <= RTCAW_PIN_IDLE;
					end else begin
						pulse_cnt_r <= pulse_cnt_r - 1'b1;
					end
				end
				default: pin_r <= RTCAW_PIN_IDLE;
			endcase
		end
	end

	assign irq_active = (pin_r != RTCAW_PIN_IDLE) & host_ok;

	// ==========================================
	// Pin source select and driver
	always_comb begin
		case ({irq_cfg_r[RTCAW_IC_FREQ_HI], irq_cfg_r[RTCAW_IC_FREQ_LO]})
			2'b00: sq_level = wave[0];
			2'b01: sq_level = wave[1];
			2'b10: sq_level = wave[2];
			default: sq_level = wave[3];
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			INT_O <= 1'b0;
			INT_OE <= 1'b0;
		end else if (!host_ok) begin
			INT_O <= 1'b0;
			INT_OE <= 1'b0;
		end else if (cal_r) begin
			INT_O <= wave[1];
			INT_OE <= 1'b1;
		end else if (irq_cfg_r[RTCAW_IC_SQW_EN]) begin
			INT_O <= sq_level;
			INT_OE <= 1'b1;
		end else if (irq_cfg_r[RTCAW_IC_HIGH]) begin
			INT_O <= irq_active;
			INT_OE <= 1'b1;
		end else begin
			INT_O <= 1'b0;
			INT_OE <= irq_active;
		end
	end
endmodule
`default_nettype wire

// File: rtcaw_top_monitor.sv
// Checker for the backup, timeout readback, flag-read and pin behaviour of rtcaw_top.
// Assumes it is bound to rtcaw_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module rtcaw_top_monitor
	import rtcaw_pkg::*;
#(
	parameter int PULSE_CYCLES = RTCAW_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [20:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	// Supply and pin
	input wire logic ON_BACKUP,
	input wire logic INT_O,
	input wire logic INT_OE
);
	// ==========================================
	// Shadow of the settings that steer the pin
	logic [7:0] cfg_r;
	logic cal_r;
	logic [5:0] tv_r;
	logic [3:0] st_r;
	logic [3:0] age_r;
	int pc_r;
	logic irq;
	logic act;
	logic fr;
	assign irq = st_r >= 4'hC && !cal_r && !cfg_r[RTCAW_IC_SQW_EN] && !ON_BACKUP;
	assign act = cfg_r[RTCAW_IC_HIGH] ? INT_O : INT_OE;
	assign fr = RD && !ON_BACKUP && (ADDR == RTCAW_OFF_EVENT_FLAGS || ADDR == RTCAW_OFF_IRQ_CONFIG);
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			cfg_r <= RTCAW_RST_IRQ_CONFIG;
			cal_r <= 1'b0;
			tv_r <= RTCAW_RST_TIMEOUT;
		end else if (WR && !ON_BACKUP) begin
			if (ADDR == RTCAW_OFF_IRQ_CONFIG)
				cfg_r <= WDATA;
			if (ADDR == RTCAW_OFF_EVENT_FLAGS)
				cal_r <= WDATA[RTCAW_FL_CAL];
			if (ADDR == RTCAW_OFF_TIMEOUT_CONTROL && !WDATA[RTCAW_TC_WRITE_LOCK])
				tv_r <= WDATA[5:0];
		end
	end
	// Cycles since the pin settings last changed, and since the last clearing read
	always_ff @(posedge MCLK) begin
		if (!RESET_N || ON_BACKUP || (WR && (ADDR == RTCAW_OFF_IRQ_CONFIG || ADDR == RTCAW_OFF_EVENT_FLAGS)))
			st_r <= 4'h0;
		else if (st_r != 4'hF)
			st_r <= st_r + 4'h1;
		if (!RESET_N || fr)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
		if (!RESET_N || !(irq && cfg_r[RTCAW_IC_PULSE] && act))
			pc_r <= 0;
		else
			pc_r <= pc_r + 1;
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	property p_tc_read;
		RD && !ON_BACKUP && ADDR == RTCAW_OFF_TIMEOUT_CONTROL |=> RDATA == {2'b00, tv_r};
	endproperty
	a_tc_read: assert property (p_tc_read) else $error("timeout value readback wrong");
	property p_high_pp;
		irq && cfg_r[RTCAW_IC_HIGH] |-> INT_OE;
	endproperty
	a_high_pp: assert property (p_high_pp) else $error("active-high pin not driven");
	property p_low_od;
		irq && !cfg_r[RTCAW_IC_HIGH] |-> !INT_O;
	endproperty
	a_low_od: assert property (p_low_od) else $error("active-low pin drives high");
	property p_level_hold;
		irq && !cfg_r[RTCAW_IC_PULSE] && act && age_r >= 4'h6 |=> act;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level interrupt dropped unread");
	property p_pulse_len;
		pc_r <= PULSE_CYCLES + 1;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse too long");
	property p_read_ends;
		irq && act && RD && ADDR == RTCAW_OFF_EVENT_FLAGS |-> ##[1:5] !act;
	endproperty
	a_read_ends: assert property (p_read_ends) else $error("flag read did not end interrupt");
	property p_wave_pp;
		st_r >= 4'hC && !ON_BACKUP && (cal_r || cfg_r[RTCAW_IC_SQW_EN]) |-> INT_OE;
	endproperty
	a_wave_pp: assert property (p_wave_pp) else $error("wave output not driven");
	property p_backup_oe;
		ON_BACKUP [*6] |-> !INT_OE;
	endproperty
	a_backup_oe: assert property (p_backup_oe) else $error("pin driven on backup");
	property p_backup_rd;
		ON_BACKUP [*4] ##0 RD |=> RDATA == 8'h00;
	endproperty
	a_backup_rd: assert property (p_backup_rd) else $error("read answered on backup");
endmodule

bind rtcaw_top rtcaw_top_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (.MCLK(MCLK), .RESET_N(RESET_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ON_BACKUP(ON_BACKUP),
	.INT_O(INT_O), .INT_OE(INT_OE));
`default_nettype wire

// File: rtcaw_top_test.sv
// Self-checking bench for rtcaw_top driven through the host model.
// Assumes the monitor binds itself; oscillator runs at MCLK/4 to keep runs short.
`timescale 1ns/100ps
`default_nettype none
module rtcaw_top_test;
	import rtcaw_pkg::*;
	localparam int PULSE = 50;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [20:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic [7:0] tsec = 8'h30;
	logic [7:0] tmin = 8'h10;
	logic [7:0] thr = 8'h05;
	logic [7:0] tdate = 8'h12;
	logic [1:0] osc_r = 2'h0;
	logic on_backup = 1'b0;
	logic supply_loss = 1'b0;
	logic backup_failed = 1'b0;
	logic int_o;
	logic int_oe;
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 848;

	always #20 mclk = ~mclk;
	always @(posedge mclk) osc_r <= osc_r + 2'h1;

	rtcaw_top #(.PULSE_CYCLES(PULSE)) uut (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .TIME_SECONDS(tsec), .TIME_MINUTES(tmin), .TIME_HOURS(thr),
		.TIME_DATE(tdate), .OSC_32K(osc_r[1]), .ON_BACKUP(on_backup), .SUPPLY_LOSS(supply_loss),
		.BACKUP_FAILED(backup_failed), .INT_O(int_o), .INT_OE(int_oe));
	rtcaw_host host (.clk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

	// ==========================================
	// Helpers
	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic rdc(input logic [20:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd8(a, d);
		chk(d, e);
	endtask
	task automatic tog(input int n, output int t);
		logic p;
		t = 0;
		p = int_o;
		repeat (n) begin
			@(posedge mclk);
			if (int_o !== p)
				t++;
			p = int_o;
		end
	endtask
	// Edges in 1024 cycles: 512 oscillator half-periods over the selected divider
	function automatic int exp_tog(input int sel);
		int div[4] = '{32768, 64, 8, 1};
		return 512 / div[sel];
	endfunction
	function automatic logic [7:0] bcd(input int lo, input int span);
		return {4'(lo + $unsigned($random(seed)) % span), 4'($unsigned($random(seed)) % 10)};
	endfunction

	// ==========================================
	// Main sequence
	initial begin
		logic [7:0] s, m, h, d, v;
		int t;
		cyc(20);
		reset_n <= 1'b1;
		rdc(RTCAW_OFF_IRQ_CONFIG, RTCAW_RST_IRQ_CONFIG);
		rdc(RTCAW_OFF_MATCH_SECONDS, 8'h00);
		rdc(RTCAW_OFF_MATCH_HOURS, 8'h80);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		rdc(21'h1FFFF1, 8'h00);
		v = 8'($random(seed)) & 8'h3F;
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, v);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'h40 | (~v & 8'h3F));
		rdc(RTCAW_OFF_TIMEOUT_CONTROL, v);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'h80);
		// Alarm with minutes excluded, level active-high pin
		host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h48);
		s = bcd(1, 5);
		m = bcd(0, 6);
		h = bcd(0, 2);
		d = bcd(1, 2);
		host.stage(s[6:0], 8'h80 | m, h, d);
		tsec <= s;
		tmin <= m ^ 8'h01;
		thr <= h;
		tdate <= d;
		cyc(6);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h02);
		tsec <= s ^ 8'h01;
		host.wr8(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		tsec <= s;
		cyc(6);
		chk({6'h0, int_oe, int_o}, 8'h03);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h40);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		tsec <= s ^ 8'h01;
		thr <= h ^ 8'h01;
		cyc(3);
		tsec <= s;
		cyc(6);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		// Every field included: exact match needed
		host.stage(s[6:0], m, h, d);
		host.wr8(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		cyc(6);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		tmin <= m;
		thr <= h;
		cyc(6);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h40);
		// Supply loss, pulse active-low pin
		host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h24);
		supply_loss <= 1'b1;
		t = 0;
		repeat (PULSE + 20) begin
			@(posedge mclk);
			if (int_oe === 1'b1)
				t++;
		end
		chk({7'h0, t >= PULSE - 1 && t <= PULSE + 1}, 8'h01);
		supply_loss <= 1'b0;
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h20);
		supply_loss <= 1'b1;
		cyc(8);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h20);
		cyc(5);
		chk({7'h0, int_oe}, 8'h00);
		supply_loss <= 1'b0;
		host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h08);
		supply_loss <= 1'b1;
		cyc(8);
		chk({6'h0, int_oe, int_o}, 8'h02);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h20);
		supply_loss <= 1'b0;
		// Timeout counter
		host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h88);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'h02);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'hC0);
		cyc(9000);
		chk({6'h0, int_oe, int_o}, 8'h03);
		rdc(RTCAW_OFF_TIMEOUT_CONTROL, 8'h02);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h80);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'hC0);
		host.rd8(RTCAW_OFF_EVENT_FLAGS, v);
		repeat (4) begin
			cyc(3000);
			host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'hC0);
		end
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		host.wr8(RTCAW_OFF_TIMEOUT_CONTROL, 8'h80);
		cyc(9000);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h00);
		// Square wave selections, then calibration output over them
		for (int i = 0; i < 4; i++) begin
			host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h10 | 8'(i));
			cyc(16);
			tog(1024, t);
			chk({7'h0, t >= exp_tog(i) - 1 && t <= exp_tog(i) + 1}, 8'h01);
		end
		host.wr8(RTCAW_OFF_EVENT_FLAGS, 8'h04);
		cyc(16);
		tog(1024, t);
		chk({7'h0, t >= exp_tog(1) - 1 && t <= exp_tog(1) + 1}, 8'h01);
		// Backup power
		on_backup <= 1'b1;
		cyc(6);
		host.wr8(RTCAW_OFF_IRQ_CONFIG, 8'h00);
		rdc(RTCAW_OFF_IRQ_CONFIG, 8'h00);
		chk({7'h0, int_oe}, 8'h00);
		on_backup <= 1'b0;
		cyc(4);
		rdc(RTCAW_OFF_IRQ_CONFIG, 8'h13);
		// Power-up with a failed backup supply
		backup_failed <= 1'b1;
		reset_n <= 1'b0;
		cyc(20);
		reset_n <= 1'b1;
		cyc(10);
		rdc(RTCAW_OFF_EVENT_FLAGS, 8'h10);
		wrap_up();
	end

	initial begin
		cyc(80000);
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
